// ==== hw/omt_sequencer.sv ====
// Offline motor tuning sequencer: step control, parameter checks and result storage.
`timescale 1ns/100ps
module omt_sequencer #(
   parameter int CW = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input omt_pkg::omt_cfg_t cfg,
   input wire logic run_cmd,
   input wire logic stop_key,
   input wire logic trip,
   input wire logic step_done,
   input wire logic step_fail,
   input wire logic [15:0] accel_time_s,
   input wire logic [15:0] decel_time_s,
   input omt_pkg::omt_consts_t measured,
   input omt_pkg::omt_consts_t default_consts,
   output logic tuning_active,
   output logic [3:0] step_code,
   output logic [6:0] speed_pct,
   output logic [7:0] display_code,
   output logic temp_settings_held,
   output omt_pkg::omt_consts_t tuned_set1,
   output omt_pkg::omt_consts_t tuned_set2,
   output omt_pkg::omt_consts_t active_consts,
   output logic params_ok,
   output logic online_tune_en
);
   import omt_pkg::*;
   omt_step_t step;
   omt_step_t next_step;
   logic run_q;
   logic start;
   logic run_drop;
   logic [6:0] slv_pct;
   logic [15:0] t_max;
   logic [CW-1:0] abort_cnt;
   logic poles_ok;
   logic freq_ok;
   logic volt_ok;
   logic cap_ok;
   logic mode_ok;
   logic brake_ok;
   logic set_ok;
   logic finishing;

   // Parameter acceptance; an unaccepted value keeps tuning from starting.
   always_comb begin
      poles_ok = (cfg.motor_pole_count != 4'h0) && !cfg.motor_pole_count[0]
         && (cfg.motor_pole_count <= POLES_MAX);
      freq_ok = (cfg.base_frequency_setting >= BASE_FREQ_MIN_HZ)
         && (cfg.base_frequency_setting <= cfg.max_frequency);
      case (cfg.regulated_voltage_select)
         9'd380, 9'd400, 9'd415, 9'd440, 9'd460, 9'd480: volt_ok = cfg.class_400v;
         default: volt_ok = !cfg.class_400v;
      endcase
      cap_ok = (cfg.motor_capacity_setting >= CAP_MIN_10W)
         && (cfg.motor_capacity_setting <= (cfg.large_model ? CAP_MAX_BIG_10W
         : CAP_MAX_10W));
      mode_ok = (cfg.tuning_mode_select == TUNE_STATIC)
         || (cfg.tuning_mode_select == TUNE_ROTATE);
      // Measurement is not possible against the brake; point braking is allowed.
      brake_ok = (cfg.dc_brake_enable == BRAKE_OFF)
         || (cfg.dc_brake_enable == BRAKE_POINT);
      set_ok = (cfg.motor_set != SET_THIRD) && (cfg.motor_set != 2'h3);
   end
   assign params_ok = poles_ok && freq_ok && volt_ok && cap_ok && brake_ok && set_ok;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
      end else begin
         run_q <= run_cmd;
      end
   end
   // A run edge outside idle is ignored, so it cannot clear a shown result or held settings.
   assign start = (step == ST_IDLE) && run_cmd && !run_q && mode_ok && params_ok;
   assign run_drop = run_q && !run_cmd;

   always_comb begin
      t_max = (accel_time_s > decel_time_s) ? accel_time_s : decel_time_s;
      if (t_max < T_LIMIT_MID_S) begin
         slv_pct = SLV_PCT_HI;
      end else if (t_max < T_LIMIT_LO_S) begin
         slv_pct = SLV_PCT_MID;
      end else begin
         slv_pct = SLV_PCT_LO;
      end
   end

   always_comb begin
      next_step = step;
      case (step)
         ST_IDLE: begin
            if (start) begin
               next_step = ST_AC1;
            end
         end
         ST_AC1: if (step_done) next_step = ST_AC2;
         ST_AC2: if (step_done) next_step = ST_DC1;
         ST_DC1: begin
            if (step_done) begin
               next_step = (cfg.tuning_mode_select == TUNE_STATIC) ? ST_DC2 : ST_VF;
            end
         end
         ST_VF: if (step_done) next_step = ST_SLV;
         ST_SLV: if (step_done) next_step = ST_DC2;
         ST_DC2: if (step_done) next_step = ST_SHOW;
         ST_SHOW: if (stop_key) next_step = ST_IDLE;
         ST_ABORT: if (stop_key || !run_cmd) next_step = ST_IDLE;
         default: next_step = ST_IDLE;
      endcase
      if (step != ST_IDLE && step != ST_SHOW && step != ST_ABORT) begin
         if (trip || step_fail || (stop_key || run_drop)
            || abort_cnt == CW'(FREE_VF_ABORT_CYC)) begin
            next_step = ST_ABORT;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step <= ST_IDLE;
      end else begin
         step <= next_step;
      end
   end

   // Free V/f is caught FREE_VF_ABORT_CYC cycles after starting, if not yet finished, rather than at once, as in the drive.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         abort_cnt <= '0;
      end else if (step == ST_IDLE || cfg.ctrl_mode != CTRL_FREE_VF) begin
         abort_cnt <= '0;
      end else if (abort_cnt != CW'(FREE_VF_ABORT_CYC)) begin
         abort_cnt <= abort_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         display_code <= DISP_NONE;
      end else if (next_step == ST_ABORT && step != ST_ABORT) begin
         if (trip) begin
            display_code <= DISP_TRIP;
         end else if (abort_cnt == CW'(FREE_VF_ABORT_CYC)) begin
            display_code <= DISP_ABNORMAL;
         end else if (step_fail || stop_key) begin
            display_code <= DISP_ERROR;
         end else begin
            display_code <= DISP_ERROR;
         end
      end else if (step == ST_DC2 && next_step == ST_SHOW) begin
         display_code <= DISP_NORMAL;
      end else if (step == ST_SHOW && stop_key) begin
         display_code <= DISP_NONE;
      end else if (start) begin
         display_code <= DISP_NONE;
      end
   end

   // Temporary tuning settings stay until a new run begins, standing in for initialisation.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         temp_settings_held <= 1'b0;
      end else if (start) begin
         temp_settings_held <= 1'b0;
      end else if (next_step == ST_ABORT && step != ST_ABORT && (stop_key || run_drop)) begin
         temp_settings_held <= 1'b1;
      end
   end

   assign finishing = (step == ST_DC2) && step_done && !trip && !step_fail && !stop_key
      && !run_drop && abort_cnt != CW'(FREE_VF_ABORT_CYC);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tuned_set1 <= '0;
         tuned_set2 <= '0;
      end else if (finishing) begin
         if (cfg.motor_set == 2'h0) begin
            tuned_set1 <= measured;
         end else if (cfg.motor_set == 2'h1) begin
            tuned_set2 <= measured;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_consts <= '0;
         online_tune_en <= 1'b0;
      end else begin
         // Tuned values only take effect through the source selection.
         if (cfg.motor_constant_source == SRC_TUNED
            || cfg.motor_constant_source == SRC_ONLINE) begin
            active_consts <= (cfg.motor_set == 2'h1) ? tuned_set2 : tuned_set1;
         end else begin
            active_consts <= default_consts;
         end
         online_tune_en <= (cfg.motor_constant_source == SRC_ONLINE);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_code <= 4'h0;
         speed_pct <= 7'h00;
         tuning_active <= 1'b0;
      end else begin
         step_code <= 4'(next_step);
         tuning_active <= (next_step != ST_IDLE) && (next_step != ST_SHOW)
            && (next_step != ST_ABORT);
         speed_pct <= (next_step == ST_VF) ? VF_SPEED_PCT
            : (next_step == ST_SLV) ? slv_pct : 7'h00;
      end
   end

   a_trip_abort: assert property (@(posedge clk) disable iff (!nrst)
      (tuning_active && trip) |=> (step == ST_ABORT) && (display_code == DISP_TRIP))
      else $error("trip did not abort tuning with trip code");
   a_static_skip: assert property (@(posedge clk) disable iff (!nrst)
      (step == ST_DC1 && step_done && cfg.tuning_mode_select == TUNE_STATIC && !trip
      && !step_fail && !stop_key && !run_drop && abort_cnt != CW'(FREE_VF_ABORT_CYC))
      |=> step == ST_DC2)
      else $error("static tuning did not skip rotating steps");
   a_start_gate: assert property (@(posedge clk) disable iff (!nrst)
      (step == ST_IDLE && $rose(run_cmd) && mode_ok && params_ok) |=> step == ST_AC1)
      else $error("run command did not start tuning");
   a_off_no_start: assert property (@(posedge clk) disable iff (!nrst)
      (step == ST_IDLE && cfg.tuning_mode_select == TUNE_OFF) |=> step == ST_IDLE)
      else $error("tuning started while disabled");
   a_slv_speed: assert property (@(posedge clk) disable iff (!nrst)
      (next_step == ST_SLV && t_max < T_LIMIT_MID_S) |=> speed_pct == SLV_PCT_HI)
      else $error("sensorless speed wrong for short ramp");
   a_clear_show: assert property (@(posedge clk) disable iff (!nrst)
      (step == ST_SHOW && stop_key) |=> (step == ST_IDLE) && (display_code == DISP_NONE))
      else $error("stop key did not clear result");
   a_stop_ends: assert property (@(posedge clk) disable iff (!nrst)
      (tuning_active && stop_key) |=> step == ST_ABORT)
      else $error("stop key did not end tuning");
   a_free_vf: assert property (@(posedge clk) disable iff (!nrst)
      (step == ST_AC1 && cfg.ctrl_mode == CTRL_FREE_VF) |-> ##[1:110] step == ST_ABORT)
      else $error("free V/f tuning did not abort");
   a_default_src: assert property (@(posedge clk) disable iff (!nrst)
      (cfg.motor_constant_source == SRC_DEFAULT) |=> active_consts == $past(default_consts))
      else $error("tuned constants used without selection");
endmodule

// ==== shared/omt_pkg.sv ====
// Package for the offline motor tuning sequencer: encodings, limits and step timing.
// Contract
// - Tuning mode 00 off, 01 static, 02 rotating.
// - Constant source 00 default, 01 tuned, 02 online.
// - Enabled mode plus run command starts tuning.
// - Six steps run in fixed order.
// - Static mode skips V/f and sensorless runs.
// - Sensorless speed 40/20/10 percent by time T.
// - DC brake 00 off, 01 on, 02 point.
// - Trip aborts at once, shows trip code.
// - Stop key or run removal ends tuning.
// - Free V/f mode ends soon, abnormal code; a run that finishes within FREE_VF_ABORT_CYC cycles ends with the normal code.
// - Stop key clears displayed result.
// - Stalled run plus stop key shows error.
// - Tuned constants used only when source 01/02.
// - Only motor sets one and two tuned.
// - Pole count accepts 2,4,6,8,10 only.
// - Base frequency from 30 Hz to maximum.
// - Voltage 380..480 list, 400 V class only.
// - Capacity 0.20-90.00 kW, 160 on large models.
package omt_pkg;
   localparam logic [1:0] TUNE_OFF = 2'h0;
   localparam logic [1:0] TUNE_STATIC = 2'h1;
   localparam logic [1:0] TUNE_ROTATE = 2'h2;
   localparam logic [1:0] SRC_DEFAULT = 2'h0;
   localparam logic [1:0] SRC_TUNED = 2'h1;
   localparam logic [1:0] SRC_ONLINE = 2'h2;
   localparam logic [1:0] BRAKE_OFF = 2'h0;
   localparam logic [1:0] BRAKE_ON = 2'h1;
   localparam logic [1:0] BRAKE_POINT = 2'h2;
   localparam logic [2:0] CTRL_FREE_VF = 3'h2;
   localparam logic [1:0] SET_THIRD = 2'h2;
   localparam logic [6:0] VF_SPEED_PCT = 7'h50;
   localparam logic [6:0] SLV_PCT_HI = 7'h28;
   localparam logic [6:0] SLV_PCT_MID = 7'h14;
   localparam logic [6:0] SLV_PCT_LO = 7'h0a;
   localparam logic [15:0] T_LIMIT_MID_S = 16'h0032;
   localparam logic [15:0] T_LIMIT_LO_S = 16'h0064;
   localparam logic [15:0] BASE_FREQ_MIN_HZ = 16'h001e;
   localparam logic [15:0] CAP_MIN_10W = 16'h0014;
   localparam logic [15:0] CAP_MAX_10W = 16'h2328;
   localparam logic [15:0] CAP_MAX_BIG_10W = 16'h3e80;
   localparam logic [3:0] POLES_MAX = 4'ha;
   localparam int FREE_VF_ABORT_NS = 1000;
   localparam int CLK_NS = 10;
   localparam int FREE_VF_ABORT_CYC = FREE_VF_ABORT_NS / CLK_NS;
   localparam logic [7:0] DISP_NONE = 8'h00;
   localparam logic [7:0] DISP_NORMAL = 8'h01;
   localparam logic [7:0] DISP_ABNORMAL = 8'h02;
   localparam logic [7:0] DISP_ERROR = 8'h03;
   localparam logic [7:0] DISP_TRIP = 8'h04;
   typedef enum {ST_IDLE, ST_AC1, ST_AC2, ST_DC1, ST_VF, ST_SLV, ST_DC2, ST_SHOW,
      ST_ABORT} omt_step_t;
   typedef struct packed {
      logic [15:0] stator_res;
      logic [15:0] rotor_res;
      logic [15:0] leak_ind;
      logic [15:0] no_load_cur;
      logic [15:0] inertia;
   } omt_consts_t;
   typedef struct packed {
      logic [1:0] tuning_mode_select;
      logic [1:0] motor_constant_source;
      logic [1:0] dc_brake_enable;
      logic [2:0] ctrl_mode;
      logic [1:0] motor_set;
      logic [3:0] motor_pole_count;
      logic [15:0] base_frequency_setting;
      logic [15:0] max_frequency;
      logic [8:0] regulated_voltage_select;
      logic class_400v;
      logic [15:0] motor_capacity_setting;
      logic large_model;
   } omt_cfg_t;
endpackage

// ==== tb/omt_motor_model.sv ====
// Behavioural motor and measuring front end seen by the tuning sequencer.
`timescale 1ns/100ps
module omt_motor_model
   import omt_pkg::*;
#(
   parameter omt_pkg::omt_consts_t FIT = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] step_code,
   input wire logic stall,
   input wire logic [7:0] lat,
   output logic step_done,
   output omt_pkg::omt_consts_t measured
);
   logic [3:0] last_step;
   logic [7:0] cnt;
   always @(negedge clk or negedge nrst) begin
      if (!nrst) begin
         last_step <= 4'h0;
         cnt <= 8'h00;
         step_done <= 1'b0;
      end else if (step_code != last_step) begin
         last_step <= step_code;
         cnt <= 8'h00;
         step_done <= 1'b0;
      end else begin
         cnt <= cnt + 8'h01;
         // A held motor never finishes its step, which is how a stalled run looks.
         step_done <= (step_code >= 4'h1) && (step_code <= 4'h6) && !stall && (cnt == lat);
      end
   end
   // Outside step codes 1 to 7 (idle and abort) the figures wander, so a stale capture cannot match by luck.
   assign measured = (step_code >= 4'h1 && step_code <= 4'h7) ? FIT : ~FIT ^ {10{cnt}};
endmodule

// ==== tb/omt_sequencer_bench.sv ====
// Self-checking bench for the tuning sequencer driven against the motor model.
`timescale 1ns/100ps
module omt_sequencer_bench;
   import omt_pkg::*;
   localparam omt_consts_t FIT = 80'h1234_2345_3456_4567_5678;
   localparam omt_consts_t DFLT = 80'h0a0a_0b0b_0c0c_0d0d_0e0e;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic run_cmd = 1'b0;
   logic stop_key = 1'b0;
   logic trip = 1'b0;
   logic step_fail = 1'b0;
   logic stall = 1'b0;
   logic [7:0] lat = 8'h02;
   logic [15:0] accel_time_s = 16'h0031;
   logic [15:0] decel_time_s = 16'h0020;
   logic [15:0] tv [4] = '{16'h0031, 16'h0032, 16'h0063, 16'h0064};
   logic [6:0] sv [4] = '{SLV_PCT_HI, SLV_PCT_MID, SLV_PCT_MID, SLV_PCT_LO};
   logic [3:0] st [5] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
   logic step_done, tuning_active, temp_settings_held, params_ok, online_tune_en;
   logic [3:0] step_code;
   logic [6:0] speed_pct;
   logic [7:0] display_code;
   omt_cfg_t cfg;
   omt_consts_t measured, tuned_set1, tuned_set2, active_consts;
   int bad_count = 0;
   int checks = 0;
   always #5 clk = ~clk;
   omt_sequencer u_omt_sequencer (.clk(clk), .nrst(nrst), .cfg(cfg), .run_cmd(run_cmd),
      .stop_key(stop_key), .trip(trip), .step_done(step_done), .step_fail(step_fail),
      .accel_time_s(accel_time_s), .decel_time_s(decel_time_s), .measured(measured),
      .default_consts(DFLT), .tuning_active(tuning_active), .step_code(step_code),
      .speed_pct(speed_pct), .display_code(display_code),
      .temp_settings_held(temp_settings_held), .tuned_set1(tuned_set1),
      .tuned_set2(tuned_set2), .active_consts(active_consts), .params_ok(params_ok),
      .online_tune_en(online_tune_en));
   omt_motor_model #(.FIT(FIT)) u_omt_motor_model (.clk(clk), .nrst(nrst),
      .step_code(step_code), .stall(stall), .lat(lat), .step_done(step_done),
      .measured(measured));
   task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic base_cfg(input logic [1:0] mode);
      cfg = '{mode, SRC_DEFAULT, BRAKE_OFF, 3'h3, 2'h0, 4'h4, 16'h0032, 16'h003c,
         9'h190, 1'b1, 16'h0190, 1'b0};
   endtask
   task automatic go();
      @(negedge clk);
      run_cmd = 1'b1;
   endtask
   // Waits for the step to move on, so a skipped or repeated step shows up.
   task automatic next_step(input logic [3:0] s);
      logic [3:0] cur;
      int n;
      cur = step_code;
      n = 0;
      while (step_code === cur && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("step", 80'(s), 80'(step_code));
   endtask
   task automatic wait_disp(input logic [7:0] v);
      int n;
      n = 0;
      while (display_code !== v && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("disp", 80'(v), 80'(display_code));
   endtask
   task automatic pchk(input logic exp);
      @(negedge clk);
      chk("params_ok", 80'(exp), 80'(params_ok));
   endtask
   task automatic clear();
      @(negedge clk);
      run_cmd = 1'b0;
      stop_key = 1'b1;
      @(negedge clk);
      stop_key = 1'b0;
      @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end
   initial begin
      base_cfg(TUNE_ROTATE);
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      go();
      next_step(4'h1);
      chk("active", 80'h1, 80'(tuning_active));
      for (int s = 2; s <= 7; s++) begin
         next_step(4'(s));
         if (s == 4) chk("speed", 80'(VF_SPEED_PCT), 80'(speed_pct));
      end
      chk("disp", 80'(DISP_NORMAL), 80'(display_code));
      chk("set1", FIT, tuned_set1);
      chk("set2", 80'h0, tuned_set2);
      chk("consts", DFLT, active_consts);
      clear();
      chk("disp", 80'(DISP_NONE), 80'(display_code));
      lat = 8'h00;
      for (int i = 0; i < 4; i++) begin
         accel_time_s = i[0] ? 16'h0005 : tv[i];
         decel_time_s = i[0] ? tv[i] : 16'h0005;
         go();
         for (int s = 1; s <= 5; s++) next_step(4'(s));
         chk("speed", 80'(sv[i]), 80'(speed_pct));
         trip = 1'b1;
         @(negedge clk);
         chk("disp", 80'(DISP_TRIP), 80'(display_code));
         trip = 1'b0;
         clear();
      end
      lat = 8'h02;
      go();
      next_step(4'h1);
      run_cmd = 1'b0;
      @(negedge clk);
      chk("disp", 80'(DISP_ERROR), 80'(display_code));
      chk("held", 80'h1, 80'(temp_settings_held));
      clear();
      base_cfg(TUNE_STATIC);
      cfg.motor_set = 2'h1;
      cfg.dc_brake_enable = BRAKE_POINT;
      cfg.motor_constant_source = SRC_ONLINE;
      go();
      foreach (st[k]) next_step(st[k]);
      chk("held", 80'h0, 80'(temp_settings_held));
      chk("set2", FIT, tuned_set2);
      // The selected constants follow the tuned set one cycle after it is written.
      @(negedge clk);
      chk("consts", FIT, active_consts);
      chk("online", 80'h1, 80'(online_tune_en));
      clear();
      cfg.motor_constant_source = SRC_TUNED;
      repeat (2) @(negedge clk);
      chk("online", 80'h0, 80'(online_tune_en));
      chk("consts", FIT, active_consts);
      stall = 1'b1;
      go();
      next_step(4'h1);
      step_fail = 1'b1;
      stop_key = 1'b1;
      @(negedge clk);
      stop_key = 1'b0;
      chk("disp", 80'(DISP_ERROR), 80'(display_code));
      step_fail = 1'b0;
      clear();
      base_cfg(TUNE_ROTATE);
      cfg.ctrl_mode = CTRL_FREE_VF;
      go();
      wait_disp(DISP_ABNORMAL);
      clear();
      stall = 1'b0;
      for (int i = 0; i < 4; i++) begin
         base_cfg(i == 0 ? TUNE_OFF : TUNE_ROTATE);
         if (i == 1) cfg.dc_brake_enable = BRAKE_ON;
         if (i == 2) cfg.motor_set = SET_THIRD;
         if (i == 3) cfg.motor_pole_count = 4'h3;
         go();
         repeat (3) @(negedge clk);
         chk("step", 80'h0, 80'(step_code));
         clear();
      end
      for (int p = 1; p <= 12; p++) begin
         cfg.motor_pole_count = 4'(p);
         pchk(p % 2 == 0 && p <= 10);
      end
      base_cfg(TUNE_OFF);
      cfg.base_frequency_setting = 16'h001d;
      pchk(1'b0);
      cfg.base_frequency_setting = 16'h003d;
      pchk(1'b0);
      cfg.base_frequency_setting = 16'h001e;
      pchk(1'b1);
      cfg.regulated_voltage_select = 9'h186;
      pchk(1'b0);
      cfg.class_400v = 1'b0;
      pchk(1'b1);
      cfg.motor_capacity_setting = 16'h2329;
      pchk(1'b0);
      cfg.large_model = 1'b1;
      pchk(1'b1);
      cfg.motor_capacity_setting = 16'h0013;
      pchk(1'b0);
      print_verdict();
   end
endmodule
